//--- shared/osw_pkg.sv
// ==========================================================================
// oscillator switch control: shared constants and types
// ==========================================================================
package osw_pkg;

    // ======================================================================
    // register bus geometry
    // ======================================================================
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // register offsets (word index on the plain register port)
    localparam logic [3:0] CTRL_OFF = 4'h0;   // oscillator_control
    localparam logic [3:0] UNLOCK_OFF = 4'h1; // unlock key port

    // ======================================================================
    // oscillator_control field positions
    // ======================================================================
    localparam int unsigned CUR_SRC_LSB = 12; // current source, read-only
    localparam int unsigned NEW_SRC_LSB = 8;  // new_source_select
    localparam int unsigned LOCK_BIT = 5;     // multiplier lock, read-only
    localparam int unsigned CF_BIT = 3;       // clock_fail_flag
    localparam int unsigned SECONDARY_OSCILLATOR_BIT = 1;     // secondary_osc_enable
    localparam int unsigned SWREQ_BIT = 0;    // switch_request

    // ======================================================================
    // unlock keys, written in order to the unlock port
    // ======================================================================
    localparam logic [15:0] UNLOCK_KEY1 = 16'h00a5;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h005a;

    // ======================================================================
    // clock sources, three-bit selection code
    // ======================================================================
    localparam logic [2:0] SRC_FAST_RC = 3'h0;      // internal_fast_rc
    localparam logic [2:0] SRC_FAST_RC_MUL = 3'h1;  // internal_rc_with_multiplier
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_MUL = 3'h3;
    localparam logic [2:0] SRC_SECONDARY = 3'h4;    // secondary_oscillator
    localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_DIVIDED_RC = 3'h7;   // divided_fast_rc

    // reset values of the control fields
    localparam logic [2:0] CUR_SRC_RST = 3'h0;
    localparam logic [2:0] NEW_SRC_RST = 3'h0;
    localparam logic [7:0] SRC_EN_RST = 8'h01;

    // ======================================================================
    // timing at 20 MHz, 50 ns period
    // ======================================================================
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned STARTUP_NS = 100000;  // multiplier start-up time
    localparam int unsigned SETTLE_NS = 100;      // gate settle each side of a change
    localparam logic [11:0] STARTUP_CYC =
        12'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] SETTLE_CYC =
        4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ======================================================================
    // state encodings, one-hot
    // ======================================================================
    typedef enum logic [2:0] {
        UL_LOCKED = 3'b001,
        UL_KEY1 = 3'b010,
        UL_OPEN = 3'b100
    } osw_unlock_t;

    typedef enum logic [3:0] {
        SW_IDLE = 4'b0001,
        SW_WAIT = 4'b0010,
        SW_CHANGE = 4'b0100,
        SW_DONE = 4'b1000
    } osw_switch_t;

    typedef enum logic [2:0] {
        CG_RUN = 3'b001,
        CG_OFF = 3'b010,
        CG_ON = 3'b100
    } osw_chg_st_t;

    // state of the control block
    typedef struct packed {
        logic [2:0] cur_src;
        logic [2:0] new_src;
        logic [2:0] tgt_src;
        logic lock;
        logic cf;
        logic secondary_oscillator_en;
        logic sw_req;
        osw_unlock_t ul;
        osw_switch_t sw;
        logic [11:0] startup_cnt;
        logic [15:0] rdata;
        logic trap;
        logic [7:0] src_en;
        logic mul_en;
        logic chg_start;
    } osw_state_t;

    // state of the changeover sequencer
    typedef struct packed {
        osw_chg_st_t st;
        logic [3:0] cnt;
        logic [2:0] sel;
        logic gate;
        logic done;
    } osw_chg_t;

endpackage : osw_pkg

//--- rtl/osw_changeover.sv
`timescale 1ns/10ps
// ==========================================================================
// glitch-free changeover: gate off, settle, move select, settle, gate on
// ==========================================================================
module osw_changeover (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [2:0] src_i,
    output logic [2:0] sel_o,
    output logic gate_en_o,
    output logic done_o
);

    osw_pkg::osw_chg_t q; // registered state
    osw_pkg::osw_chg_t d; // next state

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            // running: clock gate open on the current select
            osw_pkg::CG_RUN: begin
                if (start_i) begin
                    d.gate = 1'b0;
                    d.cnt = 4'h0;
                    d.st = osw_pkg::CG_OFF;
                end
            end
            // gate closed: let the old clock finish its last phase
            osw_pkg::CG_OFF: begin
                if (q.cnt == osw_pkg::SETTLE_CYC) begin
                    d.sel = src_i;
                    d.cnt = 4'h0;
                    d.st = osw_pkg::CG_ON;
                end else begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            // select moved: only reopen once the mux output is quiet
            osw_pkg::CG_ON: begin
                if (q.cnt == osw_pkg::SETTLE_CYC) begin
                    d.gate = 1'b1;
                    d.done = 1'b1;
                    d.st = osw_pkg::CG_RUN;
                end else begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            default: begin
                d.st = osw_pkg::CG_RUN;
                d.gate = 1'b1;
            end
        endcase
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q.st <= osw_pkg::CG_RUN;
            q.cnt <= 4'h0;
            q.sel <= osw_pkg::CUR_SRC_RST;
            q.gate <= 1'b1;
            q.done <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign sel_o = q.sel;
    assign gate_en_o = q.gate;
    assign done_o = q.done;

endmodule : osw_changeover

//--- rtl/osw_ctrl.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// - lock flag bit 5, read-only, lock or timer
// - monitor failure sets clock-fail flag bit 3
// - writing zero clears the clock-fail flag
// - writing one acts as a detected failure
// - bit 1 enables the secondary oscillator
// - setting bit 0 starts a source switch
// - bit 0 clears when switch completes
// - control writes accepted only after unlock sequence
// - control register reset only by power-on
// - no secondary: secondary selects divided fast RC
// - bits 4 and 2 read zero
module osw_ctrl (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic soft_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic has_secondary_i,
    input wire logic fail_safe_clock_monitor_i,
    input wire logic mult_lock_i,
    input wire logic [7:0] src_ready_i,
    output logic [7:0] src_en_o,
    output logic secondary_osc_enable_o,
    output logic mult_enable_o,
    output logic osc_fail_trap_o,
    output logic [2:0] clk_sel_o,
    output logic clk_gate_en_o
);

    // ======================================================================
    // state and wiring
    // ======================================================================
    osw_pkg::osw_state_t q; // registered state
    osw_pkg::osw_state_t d; // next state
    logic chg_done; // changeover finished, one-cycle pulse
    logic ctrl_wr; // accepted write to the control register
    logic unlock_wr; // any write to the unlock port
    logic fail_event; // monitor failure or software-forced failure
    logic [15:0] ctrl_view; // control register as software sees it

    // ======================================================================
    // helpers
    // ======================================================================
    // resolve a requested code to the source actually used
    function automatic logic [2:0] map_src(input logic [2:0] sel, input logic has_sec);
        logic [2:0] r;
        r = sel;
        // parts without the secondary oscillator fall back to divided RC
        if (sel == osw_pkg::SRC_SECONDARY && !has_sec) begin
            r = osw_pkg::SRC_DIVIDED_RC;
        end
        return r;
    endfunction : map_src

    // true for a source that runs through the frequency multiplier
    function automatic logic is_mul(input logic [2:0] sel);
        return (sel == osw_pkg::SRC_FAST_RC_MUL) || (sel == osw_pkg::SRC_PRIMARY_MUL);
    endfunction : is_mul

    // one-hot enable for a source code
    function automatic logic [7:0] src_bit(input logic [2:0] sel);
        logic [7:0] r;
        r = 8'h00;
        r[sel] = 1'b1;
        return r;
    endfunction : src_bit

    // ======================================================================
    // decode and read view
    // ======================================================================
    always_comb begin
        // writes reach the control register only in the open window
        ctrl_wr = wr_i && (addr_i == osw_pkg::CTRL_OFF) && (q.ul == osw_pkg::UL_OPEN);
        unlock_wr = wr_i && (addr_i == osw_pkg::UNLOCK_OFF);
        // a one written to the fail flag counts as a real failure
        fail_event = fail_safe_clock_monitor_i
            || (ctrl_wr && wdata_i[osw_pkg::CF_BIT]);
        // unused bits, bit 4 and bit 2 included, stay zero
        ctrl_view = 16'h0000;
        ctrl_view[osw_pkg::CUR_SRC_LSB +: 3] = q.cur_src;
        ctrl_view[osw_pkg::NEW_SRC_LSB +: 3] = q.new_src;
        ctrl_view[osw_pkg::LOCK_BIT] = q.lock;
        ctrl_view[osw_pkg::CF_BIT] = q.cf;
        ctrl_view[osw_pkg::SECONDARY_OSCILLATOR_BIT] = q.secondary_oscillator_en;
        ctrl_view[osw_pkg::SWREQ_BIT] = q.sw_req;
    end

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        d = q;
        d.trap = 1'b0;
        d.chg_start = 1'b0;
        d.rdata = 16'h0000;

        // ------------------------------------------------------------------
        // unlock sequence: key1 then key2 opens a single control write
        // ------------------------------------------------------------------
        if (wr_i) begin
            case (q.ul)
                osw_pkg::UL_LOCKED: begin
                    if (unlock_wr && wdata_i == osw_pkg::UNLOCK_KEY1) begin
                        d.ul = osw_pkg::UL_KEY1;
                    end
                end
                osw_pkg::UL_KEY1: begin
                    // anything but key2 right after key1 starts over
                    if (unlock_wr && wdata_i == osw_pkg::UNLOCK_KEY2) begin
                        d.ul = osw_pkg::UL_OPEN;
                    end else begin
                        d.ul = osw_pkg::UL_LOCKED;
                    end
                end
                osw_pkg::UL_OPEN: begin
                    // the window closes on the very next write of any kind
                    d.ul = osw_pkg::UL_LOCKED;
                end
                default: begin
                    d.ul = osw_pkg::UL_LOCKED;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // control register writes
        // ------------------------------------------------------------------
        if (ctrl_wr) begin
            d.new_src = wdata_i[osw_pkg::NEW_SRC_LSB +: 3];
            d.secondary_oscillator_en = wdata_i[osw_pkg::SECONDARY_OSCILLATOR_BIT];
            // a zero clears the flag; a failure below still wins
            if (!wdata_i[osw_pkg::CF_BIT]) begin
                d.cf = 1'b0;
            end
            // a zero here cannot abort a switch already under way
            if (wdata_i[osw_pkg::SWREQ_BIT]) begin
                d.sw_req = 1'b1;
            end
            // lock and current source are not taken from the write
            d.lock = q.lock;
        end

        // ------------------------------------------------------------------
        // clock failure: flag and trap, set wins over a same-cycle clear
        // ------------------------------------------------------------------
        if (fail_event) begin
            d.cf = 1'b1;
            d.trap = 1'b1;
        end

        // ------------------------------------------------------------------
        // clock switch sequence
        // ------------------------------------------------------------------
        case (q.sw)
            osw_pkg::SW_IDLE: begin
                d.src_en = src_bit(q.cur_src);
                if (q.sw_req) begin
                    // latch the target so later writes cannot move it
                    d.tgt_src = map_src(q.new_src, has_secondary_i);
                    d.src_en = src_bit(q.cur_src)
                        | src_bit(map_src(q.new_src, has_secondary_i));
                    d.sw = osw_pkg::SW_WAIT;
                end
            end
            osw_pkg::SW_WAIT: begin
                // old source keeps the system running while the new one starts
                if (src_ready_i[q.tgt_src]) begin
                    d.chg_start = 1'b1;
                    d.sw = osw_pkg::SW_CHANGE;
                end
            end
            osw_pkg::SW_CHANGE: begin
                if (chg_done) begin
                    d.cur_src = q.tgt_src;
                    d.sw = osw_pkg::SW_DONE;
                end
            end
            osw_pkg::SW_DONE: begin
                // drop the old source and report completion
                d.src_en = src_bit(q.cur_src);
                d.sw_req = 1'b0;
                d.sw = osw_pkg::SW_IDLE;
            end
            default: begin
                d.sw = osw_pkg::SW_IDLE;
            end
        endcase

        // ------------------------------------------------------------------
        // multiplier enable, start-up timer and lock flag
        // ------------------------------------------------------------------
        d.mul_en = is_mul(q.cur_src)
            || ((q.sw != osw_pkg::SW_IDLE) && is_mul(q.tgt_src));
        if (!q.mul_en) begin
            // disabled multiplier: timer restarts from zero next time
            d.startup_cnt = 12'h000;
        end else if (q.startup_cnt != osw_pkg::STARTUP_CYC) begin
            d.startup_cnt = q.startup_cnt + 12'h001;
        end
        // low while disabled, out of lock and still timing
        d.lock = d.mul_en
            && (mult_lock_i || q.startup_cnt == osw_pkg::STARTUP_CYC);

        // ------------------------------------------------------------------
        // read port: data stand in the cycle after the strobe only
        // ------------------------------------------------------------------
        if (rd_i) begin
            if (addr_i == osw_pkg::CTRL_OFF) begin
                d.rdata = ctrl_view;
            end else if (addr_i == osw_pkg::UNLOCK_OFF) begin
                d.rdata = {15'h0000, q.ul == osw_pkg::UL_OPEN};
            end else begin
                d.rdata = 16'h0000;
            end
        end

        // ------------------------------------------------------------------
        // other reset causes: bus side only, control contents survive
        // ------------------------------------------------------------------
        if (soft_rst_i) begin
            d.ul = osw_pkg::UL_LOCKED;
            d.rdata = 16'h0000;
        end
    end

    // ======================================================================
    // state register, power-on reset only
    // ======================================================================
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // defaults are loaded here and nowhere else
            q.cur_src <= osw_pkg::CUR_SRC_RST;
            q.new_src <= osw_pkg::NEW_SRC_RST;
            q.tgt_src <= osw_pkg::CUR_SRC_RST;
            q.lock <= 1'b0;
            q.cf <= 1'b0;
            q.secondary_oscillator_en <= 1'b0;
            q.sw_req <= 1'b0;
            q.ul <= osw_pkg::UL_LOCKED;
            q.sw <= osw_pkg::SW_IDLE;
            q.startup_cnt <= 12'h000;
            q.rdata <= 16'h0000;
            q.trap <= 1'b0;
            q.src_en <= osw_pkg::SRC_EN_RST;
            q.mul_en <= 1'b0;
            q.chg_start <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // changeover sequencer, owns the clock select and gate
    // ======================================================================
    osw_changeover u_changeover (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .start_i(q.chg_start),
        .src_i(q.tgt_src),
        .sel_o(clk_sel_o),
        .gate_en_o(clk_gate_en_o),
        .done_o(chg_done)
    );

    // ======================================================================
    // outputs, all straight from flip-flops
    // ======================================================================
    assign rdata_o = q.rdata;
    assign src_en_o = q.src_en;
    assign secondary_osc_enable_o = q.secondary_oscillator_en;
    assign mult_enable_o = q.mul_en;
    assign osc_fail_trap_o = q.trap;

endmodule : osw_ctrl

//--- verification/osw_osc_model.sv
`timescale 1ns/10ps
// ==========
// oscillator sources and multiplier seen from the control block
// ==========
module osw_osc_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] src_en_i,
    input wire logic mult_en_i,
    input wire logic [7:0] dly_i,
    input wire logic lock_ok_i,
    output logic [7:0] src_ready_o,
    output logic mult_lock_o
);
    logic [8:0] en;  // slot 8 is the multiplier
    logic [7:0] cnt_q [9];  // cycles each unit has run
    assign en = {mult_en_i, src_en_i};
    // run count; a stopped unit starts over
    always @(posedge ref_clk_i or negedge nrst_i) begin
        for (int i = 0; i < 9; i++) begin
            if (!nrst_i || !en[i]) begin
                cnt_q[i] <= 8'h00;
            end else if (cnt_q[i] != 8'hff) begin
                cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end
    end
    // ready drops at once when disabled
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            src_ready_o[i] = src_en_i[i] && (cnt_q[i] >= dly_i);
        end
        mult_lock_o = mult_en_i && lock_ok_i && (cnt_q[8] >= dly_i);
    end
endmodule : osw_osc_model

//--- verification/osw_ctrl_sva.sv
`timescale 1ns/10ps
// ==========
// port checks of the oscillator switch control
// ==========
module osw_ctrl_sva (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic soft_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic has_secondary_i,
    input wire logic fail_safe_clock_monitor_i,
    input wire logic mult_lock_i,
    input wire logic [7:0] src_ready_i,
    input wire logic [7:0] src_en_o,
    input wire logic secondary_osc_enable_o,
    input wire logic mult_enable_o,
    input wire logic osc_fail_trap_o,
    input wire logic [2:0] clk_sel_o,
    input wire logic clk_gate_en_o
);
    localparam logic [3:0] CA = osw_pkg::CTRL_OFF;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_fail_trap: assert property (fail_safe_clock_monitor_i |=> osc_fail_trap_o)
        else $error("no trap after monitor event");
    // a trap needs a monitor event or a write of one to the flag
    a_trap_cause: assert property (osc_fail_trap_o |->
        $past(fail_safe_clock_monitor_i) || ($past(wr_i) && $past(wdata_i[3])))
        else $error("trap without cause");
    a_unimpl_zero: assert property (rd_i && addr_i == CA |=>
        rdata_o[4] == 1'b0 && rdata_o[2] == 1'b0)
        else $error("unimplemented bit read as one");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    a_lock_off: assert property ((!mult_enable_o)[*4] ##0 (rd_i && addr_i == CA)
        |=> !rdata_o[5])
        else $error("lock reported with multiplier off");
    // select may only move while the gate is closed on both sides
    a_gate_closed: assert property ($changed(clk_sel_o) |->
        !clk_gate_en_o && !$past(clk_gate_en_o))
        else $error("select moved with gate open");
    a_sel_ready: assert property ($changed(clk_sel_o) |->
        src_en_o[clk_sel_o] && src_ready_i[clk_sel_o])
        else $error("select moved to a source not ready");
    a_secondary_oscillator_cause: assert property ($changed(secondary_osc_enable_o) |->
        $past(wr_i))
        else $error("secondary enable moved without write");
    a_soft_keep: assert property (soft_rst_i |=>
        $stable(secondary_osc_enable_o) && $stable(src_en_o))
        else $error("soft reset disturbed control");
endmodule : osw_ctrl_sva
bind osw_ctrl osw_ctrl_sva u_sva (.*);

//--- verification/osw_ctrl_tb_top.sv
`timescale 1ns/10ps
// ==========
// bench: register port, failure events and source switches
// ==========
module osw_ctrl_tb_top;
    localparam logic [3:0] CA = osw_pkg::CTRL_OFF;
    localparam logic [3:0] UA = osw_pkg::UNLOCK_OFF;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, soft_rst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic has_secondary_i = 1'b1, fail_safe_clock_monitor_i = 1'b0, lock_ok = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rdata_o, got;
    logic [7:0] src_ready_i, src_en_o, dly = 8'h01;
    logic mult_lock_i, secondary_osc_enable_o, mult_enable_o, osc_fail_trap_o, clk_gate_en_o;
    logic [2:0] clk_sel_o, cur = 3'h0, nsel = 3'h0, t;
    logic secondary_oscillator = 1'b0, cfl = 1'b0, lk_exp = 1'b0;  // expected control fields
    int err_total = 0, comparisons = 0;
    osw_ctrl dut (.*);
    osw_osc_model u_osc (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .src_en_i(src_en_o),
        .mult_en_i(mult_enable_o), .dly_i(dly), .lock_ok_i(lock_ok),
        .src_ready_o(src_ready_i), .mult_lock_o(mult_lock_i));
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // ==========
    // expectations
    // ==========
    function automatic logic mul(input logic [2:0] s);
        return s == osw_pkg::SRC_FAST_RC_MUL || s == osw_pkg::SRC_PRIMARY_MUL;
    endfunction : mul
    // parts without the secondary run the divided fast rc instead
    function automatic logic [2:0] eff(input logic [2:0] s);
        return (s == osw_pkg::SRC_SECONDARY && !has_secondary_i) ? osw_pkg::SRC_DIVIDED_RC : s;
    endfunction : eff
    function automatic logic [15:0] ctl();
        return {1'b0, cur, 1'b0, nsel, 2'b00, lk_exp, 1'b0, cfl, 1'b0, secondary_oscillator, 1'b0};
    endfunction : ctl
    // ==========
    // bus and compare tasks
    // ==========
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // one access then one idle cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 got = rdata_o;
        @(posedge ref_clk_i);
    endtask : bus
    task automatic wctl(input logic req);
        bus(1'b1, UA, osw_pkg::UNLOCK_KEY1);
        bus(1'b1, UA, osw_pkg::UNLOCK_KEY2);
        bus(1'b1, CA, {5'h00, nsel, 4'h3, cfl, 1'b1, secondary_oscillator, req});
    endtask : wctl
    task automatic rdchk();
        bus(1'b0, CA, 16'h0000);
        chk(got, ctl());
    endtask : rdchk
    task automatic outs();
        chk({src_en_o, clk_gate_en_o, mult_enable_o, secondary_osc_enable_o, 2'h0, clk_sel_o},
            {8'h01 << cur, 1'b1, mul(cur), secondary_oscillator, 2'h0, cur});
    endtask : outs
    // request a switch and poll until the request bit reads zero
    task automatic switch_to(input logic [2:0] s);
        int n = 0;
        nsel = s;
        wctl(1'b1);
        do begin
            bus(1'b0, CA, 16'h0000);
            n++;
        end while (got[0] !== 1'b0 && n < 200);
        cur = eff(s);
        lk_exp = lock_ok && mul(cur);
        chk(got, ctl());
        outs();
    endtask : switch_to
    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // main sequence
    // ==========
    initial begin
        void'($urandom(32'hec43));
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        rdchk();
        outs();
        bus(1'b0, 4'h7, 16'h0000);
        chk(got, 16'h0000);
        // no keys, then a broken key pair: both writes must be dropped
        bus(1'b1, CA, 16'h0002);
        bus(1'b1, UA, osw_pkg::UNLOCK_KEY1);
        bus(1'b1, UA, 16'h1234);
        bus(1'b1, CA, 16'h0002);
        rdchk();
        // secondary on; every control write sets bits 5, 4 and 2 too
        nsel = 3'($urandom_range(7));
        secondary_oscillator = 1'b1;
        wctl(1'b0);
        rdchk();
        outs();
        // soft reset keeps the register and shuts an open window
        bus(1'b1, UA, osw_pkg::UNLOCK_KEY1);
        bus(1'b1, UA, osw_pkg::UNLOCK_KEY2);
        soft_rst_i <= 1'b1;
        @(posedge ref_clk_i);
        soft_rst_i <= 1'b0;
        bus(1'b1, CA, 16'h0000);
        rdchk();
        // monitor event, clear by zero, set by writing one, clear again
        fail_safe_clock_monitor_i <= 1'b1;
        @(posedge ref_clk_i);
        fail_safe_clock_monitor_i <= 1'b0;
        cfl = 1'b1;
        rdchk();
        for (int i = 0; i < 3; i++) begin
            cfl = (i == 1);
            wctl(1'b0);
            rdchk();
        end
        // every source code first, then random ones with random answer delay
        for (int i = 0; i < 16; i++) begin
            t = (i < 8) ? 3'(i) : 3'($urandom_range(7));
            dly = 8'($urandom_range(30, 1));
            has_secondary_i <= 1'($urandom_range(1));
            if (mul(t) && mul(cur) && t != cur) begin
                switch_to(osw_pkg::SRC_FAST_RC);
            end
            switch_to(t);
        end
        // multiplier never locks: flag waits for the start-up timer
        if (mul(cur)) begin
            switch_to(osw_pkg::SRC_FAST_RC);
        end
        lock_ok <= 1'b0;
        switch_to(osw_pkg::SRC_FAST_RC_MUL);
        repeat (2000) @(posedge ref_clk_i);
        lk_exp = 1'b1;
        rdchk();
        // a fresh power-on reset restores every default
        nrst_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        {cur, nsel, secondary_oscillator, cfl, lk_exp} = 9'h000;
        rdchk();
        outs();
        wrap_up();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        wrap_up();
    end
endmodule : osw_ctrl_tb_top
